// *** core/wsp_pkg.sv ***
// Purpose: Shared constants and types of the waveform playback engine
// Assumes: 32-bit AXI4-Lite register bus, one 50 MHz clock
// Notes:   Offsets are byte addresses of aligned 32-bit words
package wsp_pkg;
	// Structure
	localparam int MEM_AW = 8;
	localparam int DATA_W = 16;
	localparam int FRAC_W = 24;
	localparam int AXI_AW = 8;
	localparam int CLK_HZ = 50000000;

	// Register offsets
	localparam logic [AXI_AW-1:0] OFF_CTRL  = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_LEN   = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_FREQ  = 8'h08;
	localparam logic [AXI_AW-1:0] OFF_WADDR = 8'h0C;
	localparam logic [AXI_AW-1:0] OFF_WDATA = 8'h10;
	localparam logic [AXI_AW-1:0] OFF_STAT  = 8'h14;

	// Field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_MODE_BIT = 1;
	localparam int STAT_RUN_BIT  = 16;

	// Reset values
	localparam logic [MEM_AW:0]   LEN_RST  = 9'h100;
	localparam logic [FRAC_W-1:0] FREQ_RST = 24'h000000;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Playback states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} wsp_state_t;
endpackage

// *** core/wsp_gen_if.sv ***
// Purpose: Carries settings to the address generator and the address back
// Assumes: Same clock on both sides
// Notes:   ctrl drives settings, gen returns the read address
`timescale 1ns/100ps
interface wsp_gen_if #(
	parameter int AW = 8,
	parameter int FW = 24
);
	logic          run;      // Playback active
	logic          acc_mode; // 1 = accumulator mode
	logic [AW:0]   len;      // Waveform length, 1..2**AW
	logic [FW-1:0] freq;     // Output freq as fraction of clock
	logic [AW-1:0] rd_addr;  // Memory read address

	modport ctrl (output run, acc_mode, len, freq, input rd_addr);
	modport gen  (input run, acc_mode, len, freq, output rd_addr);
endinterface

// *** core/wsp_phase.sv ***
// Purpose: Phase accumulator that produces the waveform read address
// Assumes: len already clamped to 1..2**AW by the register file
// Notes:   Phase is samples with FW fraction bits; address is its integer
`timescale 1ns/100ps
module wsp_phase #(
	parameter int AW = 8,
	parameter int FW = 24
) (
	input  wire logic clk,  // Sample clock
	input  wire logic rst,  // Async reset, active high
	wsp_gen_if.gen    g     // Settings in, address out
);
	localparam int PH_W = AW + 1 + FW;

	logic [PH_W-1:0] phase_r;
	logic [PH_W-1:0] phase_nxt;

	// One full cycle spans len samples of phase
	wire [PH_W-1:0] limit   = {g.len, {FW{1'b0}}};
	wire [PH_W-1:0] inc_dir = {{AW{1'b0}}, 1'b1, {FW{1'b0}}};
	wire [PH_W-1:0] inc_acc = {{(AW+1){1'b0}}, g.freq} * {{FW{1'b0}}, g.len};
	wire [PH_W-1:0] inc     = g.acc_mode ? inc_acc : inc_dir;
	wire [PH_W:0]   sum     = {1'b0, phase_r} + {1'b0, inc};
	wire [PH_W:0]   over    = sum - {1'b0, limit};
	wire            wrap    = sum >= {1'b0, limit};
	wire            too_far = over >= {1'b0, limit};

	// remainder kept on wrap, no realign
	// direct mode returns to sample 0
	assign phase_nxt = !g.run ? '0 :
	                   !wrap  ? sum[PH_W-1:0] :
	                   too_far ? '0 : over[PH_W-1:0];

	// Phase register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= '0;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// address is integer part of phase
	// large steps skip, small steps repeat
	assign g.rd_addr = phase_r[FW +: AW];
endmodule // wsp_phase

// *** core/wsp_top.sv ***
// Purpose: Waveform playback engine with AXI4-Lite registers
// Assumes: ref_clk 50 MHz is the sample clock; host loads memory first
// Notes:   Direct mode reads one sample a clock; accumulator mode steps phase
//
// Notes on behaviour
// - Direct mode: one sample per clock, sequential
// - Waveform length configurable, up to memory depth
// - Direct rate equals clock over length
// - Accumulator mode: fixed clock, frequency via increment
// - Binary phase spans all samples, gives address
// - Increment from length and chosen frequency
// - Big increment skips, small one repeats samples
// - Phase keeps accumulating, never realigned per cycle
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module wsp_top
	import wsp_pkg::*;
#(
	parameter int ADDR_W = wsp_pkg::MEM_AW,
	parameter int SMP_W  = wsp_pkg::DATA_W
) (
	input  wire logic                      ref_clk,       // Sample clock
	input  wire logic                      sys_rst,       // Async reset, active high
	input  wire logic [wsp_pkg::AXI_AW-1:0] s_axi_awaddr,  // Write address
	input  wire logic                      s_axi_awvalid, // Write address valid
	output logic                           s_axi_awready, // Write address ready
	input  wire logic [31:0]               s_axi_wdata,   // Write data
	input  wire logic [3:0]                s_axi_wstrb,   // Write byte strobes
	input  wire logic                      s_axi_wvalid,  // Write data valid
	output logic                           s_axi_wready,  // Write data ready
	output logic [1:0]                     s_axi_bresp,   // Write response
	output logic                           s_axi_bvalid,  // Write response valid
	input  wire logic                      s_axi_bready,  // Write response ready
	input  wire logic [wsp_pkg::AXI_AW-1:0] s_axi_araddr,  // Read address
	input  wire logic                      s_axi_arvalid, // Read address valid
	output logic                           s_axi_arready, // Read address ready
	output logic [31:0]                    s_axi_rdata,   // Read data
	output logic [1:0]                     s_axi_rresp,   // Read response
	output logic                           s_axi_rvalid,  // Read data valid
	input  wire logic                      s_axi_rready,  // Read data ready
	output logic [SMP_W-1:0]               dac_data,      // Sample to converter
	output logic                           dac_strobe     // Sample valid this clock
);
	import wsp_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [ADDR_W:0] LEN_MAX = (ADDR_W+1)'(DEPTH);
	localparam logic [ADDR_W:0] LEN_MIN = (ADDR_W+1)'(1);

	////////////////////////////////////////////////////////////////////////
	// Storage and state
	logic [SMP_W-1:0]  mem_r [DEPTH];
	logic              en_r, mode_r;
	logic [ADDR_W:0]   len_r;
	logic [FRAC_W-1:0] freq_r;
	logic [ADDR_W-1:0] waddr_r;
	wsp_state_t        state_r, state_nxt;
	logic              aw_hold_r, w_hold_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic [SMP_W-1:0]  dac_data_r;
	logic              dac_strobe_r;

	wsp_gen_if #(.AW(ADDR_W), .FW(FRAC_W)) gen_if ();

	////////////////////////////////////////////////////////////////////////
	// Decoding functions

	// Register read value at an offset, zero when unmapped
	function automatic logic [31:0] reg_read(input logic [AXI_AW-1:0] a);
		logic [31:0] v;
		v = '0;
		unique case (a)
			OFF_CTRL: begin
				v[CTRL_EN_BIT]   = en_r;
				v[CTRL_MODE_BIT] = mode_r;
			end
			OFF_LEN:   v = 32'(len_r);
			OFF_FREQ:  v = 32'(freq_r);
			OFF_WADDR: v = 32'(waddr_r);
			OFF_STAT: begin
				v[ADDR_W-1:0]   = gen_if.rd_addr;
				v[STAT_RUN_BIT] = (state_r == ST_RUN);
			end
			default:   v = '0;
		endcase
		return v;
	endfunction

	// Offset is one of the mapped registers
	function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
		return (a == OFF_CTRL) || (a == OFF_LEN) || (a == OFF_FREQ) ||
		       (a == OFF_WADDR) || (a == OFF_WDATA) || (a == OFF_STAT);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write path decoding
	wire        wr_go   = aw_hold_r && w_hold_r && !s_axi_bvalid;
	wire [31:0] wr_old  = reg_read(awaddr_r);
	logic [31:0] wr_val;
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_lane
			assign wr_val[8*gb +: 8] = wstrb_r[gb] ? wdata_r[8*gb +: 8]
			                                       : wr_old[8*gb +: 8];
		end
	endgenerate
	wire               wr_ctrl  = wr_go && (awaddr_r == OFF_CTRL);
	wire               wr_len   = wr_go && (awaddr_r == OFF_LEN);
	wire               wr_freq  = wr_go && (awaddr_r == OFF_FREQ);
	wire               wr_waddr = wr_go && (awaddr_r == OFF_WADDR);
	wire               wr_mem   = wr_go && (awaddr_r == OFF_WDATA);
	wire               len_big  = wr_val > 32'(LEN_MAX);
	wire               len_zero = wr_val == '0;
	wire [ADDR_W:0]    len_wv   = len_big ? LEN_MAX : len_zero ? LEN_MIN
	                                      : wr_val[ADDR_W:0];
	wire               ar_take  = s_axi_arvalid && s_axi_arready;

	////////////////////////////////////////////////////////////////////////
	// AXI write channels: address and data taken in either order
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			awaddr_r      <= '0;
			wdata_r       <= '0;
			wstrb_r       <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= reg_hit(awaddr_r) ? RESP_OKAY : RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_hold_r     <= 1'b0;
				w_hold_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// AXI read channel: answer one clock after address taken
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= reg_read(s_axi_araddr);
			s_axi_rresp   <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_r    <= 1'b0;
			mode_r  <= 1'b0;
			len_r   <= LEN_RST;
			freq_r  <= FREQ_RST;
			waddr_r <= '0;
		end else begin
			if (wr_ctrl) begin
				en_r   <= wr_val[CTRL_EN_BIT];
				mode_r <= wr_val[CTRL_MODE_BIT];
			end
			if (wr_len)
				len_r <= len_wv;
			if (wr_freq)
				freq_r <= wr_val[FRAC_W-1:0];
			// Loading pointer steps after each sample write
			if (wr_waddr)
				waddr_r <= wr_val[ADDR_W-1:0];
			else if (wr_mem)
				waddr_r <= waddr_r + 1'b1;
		end
	end

	// Waveform memory load
	always_ff @(posedge ref_clk) begin
		if (wr_mem)
			mem_r[waddr_r] <= wr_val[SMP_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Playback control
	// host configures before setting enable
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (en_r) state_nxt = ST_RUN;
			ST_RUN:  if (!en_r) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// accumulator mode changes only the increment
	assign gen_if.run      = (state_r == ST_RUN);
	assign gen_if.acc_mode = mode_r;
	assign gen_if.len      = len_r;
	assign gen_if.freq     = freq_r;

	wsp_phase #(.AW(ADDR_W), .FW(FRAC_W)) u_phase (
		.clk (ref_clk),
		.rst (sys_rst),
		.g   (gen_if.gen)
	);

	////////////////////////////////////////////////////////////////////////
	// Converter output
	// one sample presented every running clock
	// period is len clocks in direct mode
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_data_r   <= '0;
			dac_strobe_r <= 1'b0;
		end else begin
			dac_data_r   <= gen_if.run ? mem_r[gen_if.rd_addr] : '0;
			dac_strobe_r <= gen_if.run;
		end
	end

	assign dac_data   = dac_data_r;
	assign dac_strobe = dac_strobe_r;
endmodule // wsp_top

// *** test/wsp_top_monitor.sv ***
// Purpose: Bus and converter-side checks on the playback engine ports
// Assumes: One clock domain, reset active high
// Notes:   Bound into every wsp_top instance
`timescale 1ns/100ps
module wsp_mon #(
	parameter int SMP_W = 16
) (
	input wire logic             ref_clk,       // Clock
	input wire logic             sys_rst,       // Reset
	input wire logic             s_axi_awvalid, // Aw valid
	input wire logic             s_axi_awready, // Aw ready
	input wire logic             s_axi_wvalid,  // W valid
	input wire logic             s_axi_wready,  // W ready
	input wire logic [1:0]       s_axi_bresp,   // B code
	input wire logic             s_axi_bvalid,  // B valid
	input wire logic             s_axi_bready,  // B ready
	input wire logic             s_axi_arvalid, // Ar valid
	input wire logic             s_axi_arready, // Ar ready
	input wire logic [31:0]      s_axi_rdata,   // R data
	input wire logic             s_axi_rvalid,  // R valid
	input wire logic             s_axi_rready,  // R ready
	input wire logic [SMP_W-1:0] dac_data,      // Sample
	input wire logic             dac_strobe     // Sample valid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// Handshake steps
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	chk_write_resp: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after take");
	chk_read_resp: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read data not one cycle after take");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready) else $error("write channel not freed");
	chk_dac_quiet: assert property (!dac_strobe |-> dac_data == '0)
		else $error("sample shown without strobe");
endmodule // wsp_mon

bind wsp_top wsp_mon #(.SMP_W(SMP_W)) u_mon (.*);

// *** test/wsp_dac_model.sv ***
// Purpose: Converter model that collects every strobed sample
// Assumes: Samples are taken on the rising clock edge
// Notes:   The bench reads and clears the got queue
`timescale 1ns/100ps
module wsp_dac_model
	import wsp_pkg::*;
(
	input wire logic              clk,   // Sample clock
	input wire logic              rst,   // Reset
	input wire logic [DATA_W-1:0] data,  // Sample
	input wire logic              strobe // Sample valid
);
	logic [DATA_W-1:0] got [$];

	always @(posedge clk) begin
		if (!rst && strobe) begin
			got.push_back(data);
		end
	end
endmodule // wsp_dac_model

// *** test/tb_waveform_sample_playback.sv ***
// Purpose: Self-checking bench for the waveform playback engine
// Assumes: Fixed seed, registers reached over AXI4-Lite
// Notes:   Expected samples come from a local memory image
`timescale 1ns/100ps
module tb_waveform_sample_playback;
	import wsp_pkg::*;
	logic              ref_clk, sys_rst, dac_strobe;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	logic [DATA_W-1:0] dac_data;
	logic [DATA_W-1:0] mem [256];
	int                errors, comparisons;

	wsp_top dut (.*);
	wsp_dac_model dac (.clk(ref_clk), .rst(sys_rst), .data(dac_data), .strobe(dac_strobe));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", s, e, g);
		end
	endtask

	task automatic hang(string s);
		errors++;
		$display("ERROR %s expected answer seen timeout", s);
		conclude();
	endtask

	// Write cycle, address and data offered together
	task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		logic pa, pw, pb;
		{pa, pw, pb} = 3'h7;
		// Let an edge pass so a released strobe is not raised in the same step
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int n = 0; n < 50 && pb; n++) begin
			@(posedge ref_clk);
			if (pa && s_axi_awready) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				pb = 1'b0;
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
		if (pb) hang("write");
	endtask

	task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic pa, pb;
		{pa, pb} = 2'h3;
		// Let an edge pass so a released strobe is not raised in the same step
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (int n = 0; n < 50 && pb; n++) begin
			@(posedge ref_clk);
			if (pa && s_axi_arready) begin
				pa = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				pb = 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
		if (pb) hang("read");
	endtask

	task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// Expected read address of the i-th sample after enable
	function automatic int exp_addr(logic md, int ln, longint fq, int i);
		longint ph;
		int     a;
		ph = 0;
		a = 0;
		ln = (ln < 1) ? 1 : (ln > 256) ? 256 : ln;
		for (int k = 0; k < i; k++) begin
			a = (a + 1) % ln;
			ph += fq * ln;
			if (ph >= (longint'(ln) << 24)) ph -= longint'(ln) << 24;
		end
		return md ? int'(ph >> 24) : a;
	endfunction

	// Configure, run, stop, then compare n samples
	task automatic play(logic md, int ln, int fq, int n);
		logic [31:0] d;
		logic [1:0]  r;
		// length and frequency loaded before enable
		wr(OFF_LEN, 32'(ln), r);
		rchk(OFF_LEN, (ln < 1) ? 1 : (ln > 256) ? 256 : ln, RESP_OKAY);
		wr(OFF_FREQ, 32'(fq), r);
		dac.got.delete();
		wr(OFF_CTRL, {30'h0, md, 1'b1}, r);
		for (int k = 0; k < 2000 && dac.got.size() < n; k++) @(posedge ref_clk);
		rd(OFF_STAT, d, r);
		chk("running", 1, d[STAT_RUN_BIT]);
		wr(OFF_CTRL, 0, r);
		if (dac.got.size() < n) hang("samples");
		for (int k = 0; k < n; k++) begin
			chk("sample", mem[exp_addr(md, ln, fq, k)], dac.got[k]);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          l;
		{sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
		{s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		errors = 0;
		comparisons = 0;
		void'($urandom(77525));
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		// Reset values and unmapped places
		rchk(OFF_CTRL, 0, RESP_OKAY);
		rchk(OFF_LEN, 32'h100, RESP_OKAY);
		rchk(OFF_FREQ, 0, RESP_OKAY);
		rchk(OFF_WADDR, 0, RESP_OKAY);
		rchk(8'h18, 0, RESP_DECERR);
		wr(8'h1C, 32'hFFFFFFFF, r);
		chk("bresp", {30'h0, RESP_DECERR}, {30'h0, r});
		// Load the waveform memory with random samples
		wr(OFF_WADDR, 0, r);
		for (int i = 0; i < 256; i++) begin
			d = $urandom;
			mem[i] = d[15:0];
			wr(OFF_WDATA, d, r);
		end
		rchk(OFF_WDATA, 0, RESP_OKAY);
		// Direct playback: short, clamped to one, full depth
		l = 2 + $urandom % 39;
		play(1'b0, l, 0, 2 * l + 3);
		play(1'b0, 0, 0, 4);
		play(1'b0, 256, 0, 260);
		// Accumulator: repeating, then skipping increments
		play(1'b1, l, $urandom % 32'h400000, 80);
		play(1'b1, 300, 32'h800000 + $urandom % 32'h800000, 80);
		conclude();
	end
endmodule // tb_waveform_sample_playback
